// ---- hw/two_wire_cfg.svh ----
`ifndef TWO_WIRE_CFG_SVH
`define TWO_WIRE_CFG_SVH

// Register byte offsets
`define TW_OFF_DATA_DRIVE 6'h00
`define TW_OFF_CLOCK_DRIVE 6'h04
`define TW_OFF_CONTROL 6'h08
`define TW_OFF_FALL_COND 6'h0C
`define TW_OFF_RISE_COND 6'h10
`define TW_OFF_SAMPLED 6'h14
`define TW_OFF_NEW_SAMPLE 6'h18
`define TW_OFF_IRQ_STATUS 6'h1C
`define TW_OFF_IRQ_CLEAR 6'h20
`define TW_OFF_IRQ_ENABLE 6'h24

// Control field positions
`define TW_CTRL_ENABLE 0
`define TW_CTRL_STRETCH_EN 1
`define TW_CTRL_GATED_EN 2
`define TW_CTRL_STRETCH_ACT 3

// Interrupt status positions
`define TW_IRQ_FALL 0
`define TW_IRQ_RISE 1

// Reset values
`define TW_RST_LINE_BIT 1'b1
`define TW_RST_CONTROL 3'h0
`define TW_RST_FLAG 1'b0

`endif

// ---- hw/two_wire_pkg.sv ----
package two_wire_pkg;
    typedef logic [5:0] reg_addr_t;
    typedef logic [31:0] reg_word_t;
    typedef enum logic [1:0] {
        RESP_OKAY = 2'b00,
        RESP_DECERR = 2'b11
    } axi_resp_e;
endpackage : two_wire_pkg

// ---- hw/line_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module line_sync #(
    parameter int W = 2
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Raw pad levels
    input wire logic [W-1:0] pad,
    // Synchronised level and edges
    output logic [W-1:0] level,
    output logic [W-1:0] rise,
    output logic [W-1:0] fall
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;
    logic [W-1:0] prev_q;

    // Idle lines float high through pull-ups
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            meta_q <= '1;
            sync_q <= '1;
            prev_q <= '1;
        end
        else
        begin
            meta_q <= pad;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign level = sync_q;
    assign rise = sync_q & ~prev_q;
    assign fall = ~sync_q & prev_q;
endmodule : line_sync
`default_nettype wire

// ---- hw/axi_lite_port.sv ----
`timescale 1ns/1ps
`default_nettype none
module axi_lite_port #(
    parameter int ADDR_W = 6
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Write address and data
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // Write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // Read address and data
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Register side
    output logic wr_en,
    output logic [ADDR_W-1:0] wr_addr,
    output logic [31:0] wr_data,
    output logic [3:0] wr_strb,
    input wire logic wr_ok,
    output logic rd_en,
    input wire logic rd_ok,
    input wire logic [31:0] rd_data
);
    logic aw_held_q, aw_held_d, w_held_q, w_held_d;
    logic [ADDR_W-1:0] awaddr_q, awaddr_d;
    logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d;
    logic [3:0] wstrb_q, wstrb_d;
    logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    logic awready_q, awready_d, wready_q, wready_d, arready_q, arready_d;

    assign wr_en = aw_held_q & w_held_q & ~bvalid_q;
    assign wr_addr = awaddr_q;
    assign wr_data = wdata_q;
    assign wr_strb = wstrb_q;
    assign rd_en = arvalid & ~rvalid_q;

    always_comb
    begin
        aw_held_d = aw_held_q;
        w_held_d = w_held_q;
        awaddr_d = awaddr_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        if (awvalid && !aw_held_q && !bvalid_q)
        begin
            aw_held_d = 1'b1;
            awaddr_d = awaddr;
        end
        if (wvalid && !w_held_q && !bvalid_q)
        begin
            w_held_d = 1'b1;
            wdata_d = wdata;
            wstrb_d = wstrb;
        end
        if (wr_en)
        begin
            aw_held_d = 1'b0;
            w_held_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = wr_ok ? two_wire_pkg::RESP_OKAY : two_wire_pkg::RESP_DECERR;
        end
        else if (bvalid_q && bready)
        begin
            bvalid_d = 1'b0;
        end
        if (rd_en)
        begin
            rvalid_d = 1'b1;
            rdata_d = rd_ok ? rd_data : 32'h0000_0000;
            rresp_d = rd_ok ? two_wire_pkg::RESP_OKAY : two_wire_pkg::RESP_DECERR;
        end
        else if (rvalid_q && rready)
        begin
            rvalid_d = 1'b0;
        end
        awready_d = ~aw_held_d & ~bvalid_d;
        wready_d = ~w_held_d & ~bvalid_d;
        arready_d = ~rvalid_d;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= 2'h0;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= 2'h0;
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            arready_q <= 1'b1;
        end
        else
        begin
            aw_held_q <= aw_held_d;
            w_held_q <= w_held_d;
            awaddr_q <= awaddr_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
            awready_q <= awready_d;
            wready_q <= wready_d;
            arready_q <= arready_d;
        end
    end

    // Readies taken from next state, so bus outputs come straight from flops
    assign awready = awready_q;
    assign wready = wready_q;
    assign arready = arready_q;
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;
endmodule : axi_lite_port
`default_nettype wire

// ---- hw/two_wire_serial_assist.sv ----
`include "two_wire_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module two_wire_serial_assist #(
    parameter int ADDR_W = 6
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Serial clock line pad
    input wire logic serial_clock_line_i,
    output logic serial_clock_line_o,
    output logic serial_clock_line_oe,
    // Serial data line pad
    input wire logic serial_data_line_i,
    output logic serial_data_line_o,
    output logic serial_data_line_oe,
    // Port ownership for the port mux
    output logic lines_owned,
    // Interrupts
    output logic falling_condition_irq,
    output logic rising_condition_irq,
    output logic irq
);
    logic wr_en, wr_ok, rd_en, rd_ok;
    logic [ADDR_W-1:0] wr_addr;
    logic [31:0] wr_data, rd_data;
    logic [3:0] wr_strb;
    logic [1:0] lvl, rise, fall;
    logic scl_s, sda_s, scl_rise, scl_fall, sda_rise, sda_fall;

    logic data_line_out_bit_q, data_line_out_bit_d;
    logic clock_line_out_bit_q, clock_line_out_bit_d;
    logic block_enable_q, block_enable_d;
    logic stretch_enable_q, stretch_enable_d;
    logic gated_stretch_enable_q, gated_stretch_enable_d;
    logic stretch_active_flag_q, stretch_active_flag_d;
    logic falling_condition_bit_q, falling_condition_bit_d;
    logic rising_condition_bit_q, rising_condition_bit_d;
    logic sampled_data_bit_q, sampled_data_bit_d;
    logic new_sample_bit_q, new_sample_bit_d;
    logic [1:0] irq_status_q, irq_status_d;
    logic [1:0] irq_enable_q, irq_enable_d;
    logic irq_q, irq_d, fall_irq_q, rise_irq_q;
    logic scl_oe_q, scl_oe_d, sda_oe_q, sda_oe_d;
    logic cond1_ev, cond2_ev, stretch_set, stretch_release;

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [5:0] off);
        hit = (a == ADDR_W'(off));
    endfunction : hit

    axi_lite_port #(
        .ADDR_W(ADDR_W)
    ) u_bus (
        .aclk(aclk),
        .aresetn(aresetn),
        .awaddr(s_axi_awaddr),
        .awvalid(s_axi_awvalid),
        .awready(s_axi_awready),
        .wdata(s_axi_wdata),
        .wstrb(s_axi_wstrb),
        .wvalid(s_axi_wvalid),
        .wready(s_axi_wready),
        .bresp(s_axi_bresp),
        .bvalid(s_axi_bvalid),
        .bready(s_axi_bready),
        .araddr(s_axi_araddr),
        .arvalid(s_axi_arvalid),
        .arready(s_axi_arready),
        .rdata(s_axi_rdata),
        .rresp(s_axi_rresp),
        .rvalid(s_axi_rvalid),
        .rready(s_axi_rready),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_strb(wr_strb),
        .wr_ok(wr_ok),
        .rd_en(rd_en),
        .rd_ok(rd_ok),
        .rd_data(rd_data)
    );

    // Pads come from another domain; two flops before edge logic
    line_sync #(
        .W(2)
    ) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .pad({serial_data_line_i, serial_clock_line_i}),
        .level(lvl),
        .rise(rise),
        .fall(fall)
    );

    assign scl_s = lvl[0];
    assign sda_s = lvl[1];
    assign scl_rise = rise[0];
    assign scl_fall = fall[0];
    assign sda_rise = rise[1];
    assign sda_fall = fall[1];

    // Line events, only while the block owns the lines
    assign cond1_ev = block_enable_q & sda_fall & scl_s;
    assign cond2_ev = block_enable_q & sda_rise & scl_s;
    // Gated mode looks at the flag as it stood before this fall
    assign stretch_set = block_enable_q & scl_fall
        & (stretch_enable_q | (gated_stretch_enable_q & falling_condition_bit_q));
    assign stretch_release = wr_en & hit(wr_addr, `TW_OFF_SAMPLED);

    // Unmapped addresses answer DECERR
    always_comb
    begin
        wr_ok = 1'b1;
        unique case (wr_addr)
            ADDR_W'(`TW_OFF_DATA_DRIVE), ADDR_W'(`TW_OFF_CLOCK_DRIVE),
            ADDR_W'(`TW_OFF_CONTROL), ADDR_W'(`TW_OFF_FALL_COND),
            ADDR_W'(`TW_OFF_RISE_COND), ADDR_W'(`TW_OFF_SAMPLED),
            ADDR_W'(`TW_OFF_NEW_SAMPLE), ADDR_W'(`TW_OFF_IRQ_STATUS),
            ADDR_W'(`TW_OFF_IRQ_CLEAR), ADDR_W'(`TW_OFF_IRQ_ENABLE): wr_ok = 1'b1;
            default: wr_ok = 1'b0;
        endcase
    end

    // Upper bits stay zero on every register
    always_comb
    begin
        rd_ok = 1'b1;
        rd_data = 32'h0000_0000;
        unique case (s_axi_araddr)
            ADDR_W'(`TW_OFF_DATA_DRIVE): rd_data[0] = sda_s;
            ADDR_W'(`TW_OFF_CLOCK_DRIVE): rd_data[0] = scl_s;
            ADDR_W'(`TW_OFF_CONTROL):
            begin
                rd_data[`TW_CTRL_ENABLE] = block_enable_q;
                rd_data[`TW_CTRL_STRETCH_EN] = stretch_enable_q;
                rd_data[`TW_CTRL_GATED_EN] = gated_stretch_enable_q;
                rd_data[`TW_CTRL_STRETCH_ACT] = stretch_active_flag_q;
            end
            ADDR_W'(`TW_OFF_FALL_COND): rd_data[0] = falling_condition_bit_q;
            ADDR_W'(`TW_OFF_RISE_COND): rd_data[0] = rising_condition_bit_q;
            ADDR_W'(`TW_OFF_SAMPLED): rd_data[0] = sampled_data_bit_q;
            ADDR_W'(`TW_OFF_NEW_SAMPLE): rd_data[0] = new_sample_bit_q;
            ADDR_W'(`TW_OFF_IRQ_STATUS): rd_data[1:0] = irq_status_q;
            ADDR_W'(`TW_OFF_IRQ_CLEAR): rd_data[1:0] = 2'h0;
            ADDR_W'(`TW_OFF_IRQ_ENABLE): rd_data[1:0] = irq_enable_q;
            default: rd_ok = 1'b0;
        endcase
    end

    always_comb
    begin
        data_line_out_bit_d = data_line_out_bit_q;
        clock_line_out_bit_d = clock_line_out_bit_q;
        block_enable_d = block_enable_q;
        stretch_enable_d = stretch_enable_q;
        gated_stretch_enable_d = gated_stretch_enable_q;
        irq_enable_d = irq_enable_q;
        if (wr_en && wr_strb[0])
        begin
            if (hit(wr_addr, `TW_OFF_DATA_DRIVE))
            begin
                data_line_out_bit_d = wr_data[0];
            end
            if (hit(wr_addr, `TW_OFF_CLOCK_DRIVE))
            begin
                clock_line_out_bit_d = wr_data[0];
            end
            if (hit(wr_addr, `TW_OFF_CONTROL))
            begin
                block_enable_d = wr_data[`TW_CTRL_ENABLE];
                stretch_enable_d = wr_data[`TW_CTRL_STRETCH_EN];
                gated_stretch_enable_d = wr_data[`TW_CTRL_GATED_EN];
            end
            if (hit(wr_addr, `TW_OFF_IRQ_ENABLE))
            begin
                irq_enable_d = wr_data[1:0];
            end
        end
    end

    // Flags: hardware set wins over a software clear in the same cycle
    always_comb
    begin
        falling_condition_bit_d = falling_condition_bit_q;
        rising_condition_bit_d = rising_condition_bit_q;
        stretch_active_flag_d = stretch_active_flag_q;
        sampled_data_bit_d = sampled_data_bit_q;
        new_sample_bit_d = new_sample_bit_q;
        irq_status_d = irq_status_q;
        if (wr_en && hit(wr_addr, `TW_OFF_FALL_COND))
        begin
            falling_condition_bit_d = 1'b0;
        end
        if (wr_en && hit(wr_addr, `TW_OFF_RISE_COND))
        begin
            rising_condition_bit_d = 1'b0;
        end
        if (cond1_ev)
        begin
            falling_condition_bit_d = 1'b1;
        end
        if (cond2_ev)
        begin
            rising_condition_bit_d = 1'b1;
        end
        if (stretch_release || !block_enable_q)
        begin
            stretch_active_flag_d = 1'b0;
        end
        if (stretch_set)
        begin
            stretch_active_flag_d = 1'b1;
        end
        if (rd_en && hit(s_axi_araddr, `TW_OFF_SAMPLED))
        begin
            new_sample_bit_d = 1'b0;
        end
        if (block_enable_q && scl_rise)
        begin
            sampled_data_bit_d = sda_s;
            new_sample_bit_d = 1'b1;
        end
        if (wr_en && hit(wr_addr, `TW_OFF_IRQ_CLEAR))
        begin
            irq_status_d = irq_status_q & ~wr_data[1:0];
        end
        irq_status_d[`TW_IRQ_FALL] = irq_status_d[`TW_IRQ_FALL] | cond1_ev;
        irq_status_d[`TW_IRQ_RISE] = irq_status_d[`TW_IRQ_RISE] | cond2_ev;
        irq_d = |(irq_status_d & irq_enable_d);
        // Open drain: only ever pull low, never drive high
        sda_oe_d = block_enable_q & ~data_line_out_bit_q;
        scl_oe_d = block_enable_q & (~clock_line_out_bit_q | stretch_active_flag_d);
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            data_line_out_bit_q <= `TW_RST_LINE_BIT;
            clock_line_out_bit_q <= `TW_RST_LINE_BIT;
            {gated_stretch_enable_q, stretch_enable_q, block_enable_q} <= `TW_RST_CONTROL;
            stretch_active_flag_q <= `TW_RST_FLAG;
            falling_condition_bit_q <= `TW_RST_FLAG;
            rising_condition_bit_q <= `TW_RST_FLAG;
            sampled_data_bit_q <= `TW_RST_FLAG;
            new_sample_bit_q <= `TW_RST_FLAG;
            irq_status_q <= 2'h0;
            irq_enable_q <= 2'h0;
            irq_q <= 1'b0;
            fall_irq_q <= 1'b0;
            rise_irq_q <= 1'b0;
            scl_oe_q <= 1'b0;
            sda_oe_q <= 1'b0;
        end
        else
        begin
            data_line_out_bit_q <= data_line_out_bit_d;
            clock_line_out_bit_q <= clock_line_out_bit_d;
            block_enable_q <= block_enable_d;
            stretch_enable_q <= stretch_enable_d;
            gated_stretch_enable_q <= gated_stretch_enable_d;
            stretch_active_flag_q <= stretch_active_flag_d;
            falling_condition_bit_q <= falling_condition_bit_d;
            rising_condition_bit_q <= rising_condition_bit_d;
            sampled_data_bit_q <= sampled_data_bit_d;
            new_sample_bit_q <= new_sample_bit_d;
            irq_status_q <= irq_status_d;
            irq_enable_q <= irq_enable_d;
            irq_q <= irq_d;
            fall_irq_q <= cond1_ev;
            rise_irq_q <= cond2_ev;
            scl_oe_q <= scl_oe_d;
            sda_oe_q <= sda_oe_d;
        end
    end

    assign serial_clock_line_o = 1'b0;
    assign serial_data_line_o = 1'b0;
    assign serial_clock_line_oe = scl_oe_q;
    assign serial_data_line_oe = sda_oe_q;
    assign lines_owned = block_enable_q;
    assign falling_condition_irq = fall_irq_q;
    assign rising_condition_irq = rise_irq_q;
    assign irq = irq_q;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sample_capture_a: assert property (block_enable_q && scl_rise |=> sampled_data_bit_q == $past(sda_s))
        else $error("sampled bit did not take data level on clock rise");
    new_sample_set_a: assert property (block_enable_q && scl_rise |=> new_sample_bit_q)
        else $error("new sample flag not set on clock rise");
    falling_cond_a: assert property (block_enable_q && sda_fall && scl_s |=> falling_condition_bit_q && irq_status_q[0])
        else $error("falling condition missed");
    rising_cond_a: assert property (block_enable_q && sda_rise && scl_s |=> rising_condition_bit_q && rise_irq_q)
        else $error("rising condition missed");
    cond_clear_a: assert property (wr_en && hit(wr_addr, `TW_OFF_FALL_COND) && !cond1_ev |=> !falling_condition_bit_q)
        else $error("falling condition flag not cleared by write");
    stretch_hold_a: assert property (stretch_active_flag_q |-> scl_oe_q)
        else $error("clock not held low while stretching");
    gated_stretch_a: assert property (block_enable_q && scl_fall && !stretch_enable_q && !falling_condition_bit_q && !stretch_active_flag_q |=> !stretch_active_flag_q)
        else $error("gated stretch without prior falling condition");
    stretch_release_a: assert property (stretch_release && !stretch_set |=> !stretch_active_flag_q)
        else $error("stretch not released by write");
    drive_low_a: assert property (block_enable_q && !data_line_out_bit_q |=> sda_oe_q)
        else $error("data line not pulled low");
    disabled_idle_a: assert property (!block_enable_q [*2] |-> !sda_oe_q && !scl_oe_q && !stretch_active_flag_q)
        else $error("disabled block drives a line");
    irq_level_a: assert property (|(irq_status_q & irq_enable_q) |-> irq_q)
        else $error("interrupt output low with enabled status set");
endmodule : two_wire_serial_assist
`default_nettype wire

// ---- dv/serial_peer.sv ----
`timescale 1ns/1ps
`default_nettype none
module serial_peer (
    // Clock
    input wire logic aclk,
    // Open-drain pulls, high pulls the line low
    output var logic scl_pull,
    output var logic sda_pull
);
    initial
    begin
        scl_pull = 1'h0;
        sda_pull = 1'h0;
    end
    // Released lines float to the pull-up level, never hold a stale value
    task automatic lines(input logic c, input logic d);
        @(posedge aclk);
        scl_pull <= !c;
        sda_pull <= !d;
        repeat (4) @(posedge aclk);
    endtask : lines
    // Data set while clock low, so no condition fires mid-bit
    task automatic send_bit(input logic d);
        lines(1'h0, d);
        lines(1'h1, d);
        lines(1'h0, d);
    endtask : send_bit
endmodule : serial_peer
`default_nettype wire

// ---- dv/two_wire_serial_assist_tb.sv ----
`include "two_wire_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module two_wire_serial_assist_tb;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic [5:0] awaddr = 6'h00, araddr = 6'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hF;
    logic awready, wready, bvalid, arready, rvalid, scl_oe, sda_oe, scl_o, sda_o;
    logic owned, fall_irq, rise_irq, irq, scl_pull, sda_pull;
    logic [31:0] rdata;
    logic [1:0] bresp, rresp, last_resp;
    int num_errors = 0;
    int comparisons = 0;
    int fall_seen = 0;
    int rise_seen = 0;
    wire logic scl_w = !(scl_oe | scl_pull);
    wire logic sda_w = !(sda_oe | sda_pull);

    always #12.5 aclk = !aclk;

    // Interrupt pulses last one cycle, so count them where they are settled
    always @(negedge aclk)
    begin
        if (fall_irq === 1'h1)
            fall_seen++;
        if (rise_irq === 1'h1)
            rise_seen++;
    end

    two_wire_serial_assist uut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .serial_clock_line_i(scl_w), .serial_clock_line_o(scl_o),
        .serial_clock_line_oe(scl_oe), .serial_data_line_i(sda_w),
        .serial_data_line_o(sda_o), .serial_data_line_oe(sda_oe),
        .lines_owned(owned), .falling_condition_irq(fall_irq),
        .rising_condition_irq(rise_irq), .irq(irq));

    serial_peer peer (.aclk(aclk), .scl_pull(scl_pull), .sda_pull(sda_pull));

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e)
        begin
            $display("BAD %s expected %h seen %h", n, e, g);
            num_errors++;
        end
    endtask : chk

    // Handshakes sampled at the falling edge, where flop outputs are settled
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        logic ta, tw, tb;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        tb = 1'h0;
        while (!tb)
        begin
            @(negedge aclk);
            ta = awvalid & awready;
            tw = wvalid & wready;
            tb = bvalid;
            last_resp = bresp;
            @(posedge aclk);
            if (ta)
                awvalid <= 1'h0;
            if (tw)
                wvalid <= 1'h0;
        end
        bready <= 1'h0;
    endtask : wr

    task automatic rd(input logic [5:0] a, input logic [31:0] e, input string n);
        logic done, ta;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        done = 1'h0;
        while (!done)
        begin
            @(negedge aclk);
            ta = arvalid & arready;
            done = rvalid;
            if (done)
                chk(n, e, rdata);
            last_resp = rresp;
            @(posedge aclk);
            if (ta)
                arvalid <= 1'h0;
        end
        rready <= 1'h0;
    endtask : rd

    task automatic settle(input int n);
        repeat (n) @(posedge aclk);
        @(negedge aclk);
    endtask : settle

    task automatic t_reset;
        rd(`TW_OFF_DATA_DRIVE, 32'h1, "data_pad");
        rd(`TW_OFF_CLOCK_DRIVE, 32'h1, "clock_pad");
        rd(`TW_OFF_CONTROL, 32'h0, "control");
        rd(`TW_OFF_SAMPLED, 32'h0, "sampled");
        rd(`TW_OFF_NEW_SAMPLE, 32'h0, "new_sample");
        rd(6'h28, 32'h0, "unmapped");
        chk("rresp", {30'h0, two_wire_pkg::RESP_DECERR}, {30'h0, last_resp});
        wr(6'h28, 32'hFFFFFFFF);
        chk("bresp", {30'h0, two_wire_pkg::RESP_DECERR}, {30'h0, last_resp});
    endtask : t_reset

    // Data moved only while clock is low, so no condition fires here
    task automatic t_drive;
        wr(`TW_OFF_CONTROL, 32'h1);
        settle(2);
        chk("owned", 32'h1, {31'h0, owned});
        chk("oe_idle", 32'h0, {30'h0, scl_oe, sda_oe});
        wr(`TW_OFF_CLOCK_DRIVE, 32'h0);
        settle(4);
        rd(`TW_OFF_CLOCK_DRIVE, 32'h0, "clock_pad");
        wr(`TW_OFF_DATA_DRIVE, 32'hFFFFFFFE);
        settle(4);
        chk("sda_oe", 32'h1, {31'h0, sda_oe});
        rd(`TW_OFF_DATA_DRIVE, 32'h0, "data_pad");
        wr(`TW_OFF_DATA_DRIVE, 32'h1);
        wr(`TW_OFF_CLOCK_DRIVE, 32'h1);
    endtask : t_drive

    task automatic t_cond;
        wr(`TW_OFF_IRQ_ENABLE, 32'h3);
        peer.lines(1'h1, 1'h0);
        settle(2);
        rd(`TW_OFF_DATA_DRIVE, 32'h0, "data_pad");
        rd(`TW_OFF_FALL_COND, 32'h1, "fall_flag");
        chk("irq", 32'h1, {31'h0, irq});
        chk("fall_irq", 32'h1, fall_seen);
        wr(`TW_OFF_FALL_COND, 32'h0);
        rd(`TW_OFF_FALL_COND, 32'h0, "fall_flag");
        peer.lines(1'h1, 1'h1);
        settle(2);
        rd(`TW_OFF_RISE_COND, 32'h1, "rise_flag");
        chk("rise_irq", 32'h1, rise_seen);
        rd(`TW_OFF_IRQ_STATUS, 32'h3, "irq_status");
        wr(`TW_OFF_RISE_COND, 32'h5);
        wr(`TW_OFF_IRQ_CLEAR, 32'h3);
        settle(1);
        chk("irq_clear", 32'h0, {31'h0, irq});
    endtask : t_cond

    task automatic t_sample;
        peer.lines(1'h0, 1'h1);
        peer.send_bit(1'h0);
        settle(2);
        rd(`TW_OFF_NEW_SAMPLE, 32'h1, "new_sample");
        rd(`TW_OFF_SAMPLED, 32'h0, "sampled");
        rd(`TW_OFF_NEW_SAMPLE, 32'h0, "new_sample");
        peer.send_bit(1'h1);
        settle(2);
        rd(`TW_OFF_SAMPLED, 32'h1, "sampled");
    endtask : t_sample

    // Peer waits past the fall before releasing, so the hold is the block's own
    task automatic t_stretch;
        wr(`TW_OFF_CONTROL, 32'h3);
        peer.lines(1'h1, 1'h1);
        peer.lines(1'h0, 1'h1);
        settle(4);
        peer.lines(1'h1, 1'h1);
        settle(0);
        chk("scl_oe", 32'h1, {31'h0, scl_oe});
        rd(`TW_OFF_CONTROL, 32'hB, "control");
        wr(`TW_OFF_SAMPLED, 32'h0);
        settle(4);
        chk("scl_oe", 32'h0, {31'h0, scl_oe});
        rd(`TW_OFF_CONTROL, 32'h3, "control");
        wr(`TW_OFF_CONTROL, 32'h5);
        peer.lines(1'h0, 1'h1);
        settle(4);
        chk("scl_oe", 32'h0, {31'h0, scl_oe});
        peer.lines(1'h1, 1'h1);
        peer.lines(1'h1, 1'h0);
        peer.lines(1'h0, 1'h0);
        settle(4);
        chk("scl_oe", 32'h1, {31'h0, scl_oe});
        wr(`TW_OFF_SAMPLED, 32'h0);
        chk("fall_irq", 32'h2, fall_seen);
    endtask : t_stretch

    // Mid-run reset must drop the sticky falling condition left by the stretch test
    task automatic t_rerst;
        rd(`TW_OFF_FALL_COND, 32'h1, "fall_flag");
        @(posedge aclk);
        aresetn <= 1'h0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        rd(`TW_OFF_FALL_COND, 32'h0, "fall_flag");
        rd(`TW_OFF_CONTROL, 32'h0, "control");
    endtask : t_rerst

    task automatic end_sim;
        if (num_errors == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_sim

    initial
    begin
        repeat (5000) @(posedge aclk);
        num_errors++;
        end_sim();
    end

    initial
    begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        t_reset();
        t_drive();
        t_cond();
        t_sample();
        t_stretch();
        t_rerst();
        end_sim();
    end
endmodule : two_wire_serial_assist_tb
`default_nettype wire
